// ==== verilog/conv_ctrl_pkg.sv ====
// Package for the converter control and result register block.
// Assumes a byte-wide register map reached over a 32-bit Avalon-MM slave.
package conv_ctrl_pkg;

  // Printed register offsets are not word multiples: they are indices, byte address = 4 * index
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h3C;
  localparam logic [7:0] IDX_RESULT_HIGH    = 8'h3D;
  localparam logic [7:0] IDX_RESULT_LOW     = 8'h3E;
  localparam logic [7:0] IDX_CLOCK_CONFIG   = 8'h3F;
  localparam int         ADDR_W             = 10;

  // Status/control field positions
  localparam int DONE_BIT  = 7;
  localparam int IRQEN_BIT = 6;
  localparam int CONT_BIT  = 5;

  // Clock configuration field positions
  localparam int FMT_HI_BIT  = 3;
  localparam int FMT_LO_BIT  = 2;

  // Reset values
  localparam logic [4:0] CHANNEL_RESET   = 5'h1F;
  localparam logic [7:0] CLKCFG_RESET    = 8'h04;
  localparam logic [1:0] FORMAT_RESET    = 2'h1;

  // Channel codes
  localparam logic [4:0] CH_BANDGAP      = 5'h06;
  localparam logic [4:0] CH_REF_HIGH     = 5'h1D;
  localparam logic [4:0] CH_REF_LOW      = 5'h1E;
  localparam logic [4:0] CH_POWER_OFF    = 5'h1F;

  // Conversion timing in converter clock cycles
  localparam int         CONV_CYCLES_MIN = 16;
  localparam int         CONV_CYCLES_MAX = 17;
  localparam logic [4:0] CONV_COUNT      = 5'd16;

  typedef enum logic [1:0]
  {
    FMT_TRUNC8,
    FMT_RIGHT,
    FMT_LEFT,
    FMT_LEFT_SIGNED
  } format_e;

  // Request to the analog core
  typedef struct packed
  {
    logic       start;
    logic [4:0] channel;
    logic       power_down;
  } core_req_s;

endpackage : conv_ctrl_pkg

// ==== verilog/conv_ctrl.sv ====
// Converter status/control, clock configuration and result registers.
// Assumes a converter clock enable from the prescaler and a 10-bit sample from the core.
//
// Functional notes
// [R1] Writing status/control aborts and restarts conversion on the new channel.
// [R2] With interrupts off, done flag is read-only, set at each completion.
// [R3] Done flag cleared by status write, clock config write or low result read.
// [R4] With interrupt enable set, done reads 0 and a request is raised.
// [R5] Request withdrawn on low result read or status/control write.
// [R6] Reset clears the done flag.
// [R7] Reset clears the interrupt enable.
// [R8] Continuous bit repeats conversions; clear gives one per start; reset clears.
// [R9] Five-bit channel select: 0..5 pins, 6 bandgap.
// [R10] Codes 7..28 reserved; results undefined.
// [R11] 29 high reference, 30 low reference, 31 powers off (reset value).
// [R12] Software discards first conversion after leaving power-off.
// [R13] High and low registers present the result in the chosen format.
// [R14] Truncated: low gets bits 9:2, high reads zero.
// [R15] Truncated: no interlock, low overwritten every completion.
// [R16] Right-justified: high 1:0 gets bits 9:8, low gets 7:0.
// [R17] Left-justified: high gets 9:2, low 7:6 gets 1:0.
// [R18] Justified modes: high read freezes low; results dropped until low read.
// [R19] Format field: 00 trunc, 01 right, 10 left, 11 signed; reset right.
// [R20] Signed left format inverts the most significant result bit.
// [R21] Conversion takes sixteen to seventeen converter clock cycles.
// [R22] Result writes ignored; results read zero after reset.
// [R23] Interrupt request is a level held until cleared, only when enabled.
`timescale 1ns/1ps

module conv_ctrl
  import conv_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Avalon-MM slave
  input  wire logic [conv_ctrl_pkg::ADDR_W-1:0] address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [3:0]                    byteenable,
  input  wire logic [31:0]                   writedata,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  // Analog core side
  input  wire logic                          conv_tick,
  input  wire logic [9:0]                    sample,
  output conv_ctrl_pkg::core_req_s           core_req,
  output logic      [7:0]                    conv_clock_config,
  // Interrupt request
  output logic                               conv_irq
);
  import conv_ctrl_pkg::*;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_CONVERT,
    ST_DONE
  } conv_state_e;

  logic [4:0]  channel_select;
  logic        conv_irq_enable;
  logic        continuous_conv;
  logic        conversion_done_flag;
  logic [7:0]  conv_result_high;
  logic [7:0]  conv_result_low;
  logic        low_frozen;
  logic [4:0]  cycle_count;
  logic        acked;
  logic        start_pulse;
  conv_state_e state;

  // Decoded bus strobes
  logic [7:0] reg_index;
  logic       bus_req;
  logic       take;
  logic       wr_status;
  logic       wr_clock;
  logic       rd_high;
  logic       rd_low;
  logic       complete;
  format_e    format;
  logic [9:0] shaped;

  assign reg_index = address[ADDR_W-1:2];
  assign bus_req   = read | write;
  // One wait state lets read data come from flops
  assign take        = bus_req & acked;
  assign waitrequest = bus_req & ~acked;
  assign wr_status = take & write & byteenable[0] & (reg_index == IDX_STATUS_CONTROL);
  assign wr_clock  = take & write & byteenable[0] & (reg_index == IDX_CLOCK_CONFIG);
  assign rd_high   = take & read & (reg_index == IDX_RESULT_HIGH);
  assign rd_low    = take & read & (reg_index == IDX_RESULT_LOW);
  assign format    = format_e'({conv_clock_config[FMT_HI_BIT], conv_clock_config[FMT_LO_BIT]}); // [R19]

  always_ff @(posedge sys_clk)
  begin
    if (rst | take)
      acked <= 1'b0;
    else if (bus_req)
      acked <= 1'b1;
  end

  // Status/control fields
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      channel_select  <= CHANNEL_RESET; // [R11]
      conv_irq_enable <= 1'b0;          // [R7]
      continuous_conv <= 1'b0;          // [R8]
    end
    else if (wr_status)
    begin
      channel_select  <= writedata[4:0]; // [R9] [R10]
      conv_irq_enable <= writedata[IRQEN_BIT];
      continuous_conv <= writedata[CONT_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      conv_clock_config <= CLKCFG_RESET; // [R19]
    else if (wr_clock)
      conv_clock_config <= writedata[7:0];
  end

  // Sequencer; a status write restarts from scratch
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state       <= ST_IDLE;
      cycle_count <= 5'd0;
    end
    else if (wr_status)
    begin
      state       <= (writedata[4:0] == CH_POWER_OFF) ? ST_IDLE : ST_CONVERT; // [R1] [R11]
      cycle_count <= 5'd0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          cycle_count <= 5'd0;
        ST_CONVERT:
          // Start tick is fractional, so 16 counted ticks give 16 to 17 cycles
          if (conv_tick)
          begin
            if (cycle_count == CONV_COUNT - 5'd1)
              state <= ST_DONE; // [R21]
            cycle_count <= cycle_count + 5'd1;
          end
        ST_DONE:
        begin
          cycle_count <= 5'd0;
          state       <= continuous_conv ? ST_CONVERT : ST_IDLE; // [R8]
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  assign complete = (state == ST_DONE);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      start_pulse <= 1'b0;
    else
      start_pulse <= wr_status | (complete & continuous_conv);
  end

  always_comb
  begin
    core_req.start      = start_pulse;
    core_req.channel    = channel_select;
    core_req.power_down = (channel_select == CH_POWER_OFF);
  end

  // Done flag: completion wins over a same-cycle clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      conversion_done_flag <= 1'b0; // [R6]
    else if (complete)
      conversion_done_flag <= 1'b1; // [R2]
    else if (wr_status | wr_clock | rd_low)
      conversion_done_flag <= 1'b0; // [R3]
  end

  // Level request, only while enabled
  assign conv_irq = conversion_done_flag & conv_irq_enable; // [R4] [R5] [R23]

  // Result formatting
  always_comb
  begin
    shaped = sample;
    if (format == FMT_LEFT_SIGNED)
      shaped[9] = ~sample[9]; // [R20]
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      low_frozen <= 1'b0;
    else if (rd_low | format == FMT_TRUNC8)
      low_frozen <= 1'b0; // [R15]
    else if (rd_high)
      low_frozen <= 1'b1; // [R18]
  end

  // Results ignore bus writes entirely
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      conv_result_high <= 8'h00; // [R22]
      conv_result_low  <= 8'h00;
    end
    else if (complete & (~low_frozen | format == FMT_TRUNC8))
    begin
      case (format) // [R13]
        FMT_TRUNC8:
        begin
          conv_result_high <= 8'h00;        // [R14]
          conv_result_low  <= shaped[9:2];
        end
        FMT_RIGHT:
        begin
          conv_result_high <= {6'h00, shaped[9:8]}; // [R16]
          conv_result_low  <= shaped[7:0];
        end
        default:
        begin
          conv_result_high <= shaped[9:2];          // [R17]
          conv_result_low  <= {shaped[1:0], 6'h00};
        end
      endcase
    end
  end

  // Read data from flops, registered during the wait state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (bus_req & ~acked & read)
    begin
      case (reg_index)
        IDX_STATUS_CONTROL:
          readdata <= {24'h000000, conversion_done_flag & ~conv_irq_enable, // [R4]
                       conv_irq_enable, continuous_conv, channel_select};
        IDX_RESULT_HIGH:
          readdata <= {24'h000000, conv_result_high};
        IDX_RESULT_LOW:
          readdata <= {24'h000000, conv_result_low};
        IDX_CLOCK_CONFIG:
          readdata <= {24'h000000, conv_clock_config};
        default:
          readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : conv_ctrl

// ==== sim/conv_ctrl_chk.sv ====
// Port checker for conv_ctrl.
// Assumes one clock and a bind to the design top.
`timescale 1ns/1ps
module conv_ctrl_chk
  import conv_ctrl_pkg::*;
(
  // Bus
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic [9:0]              address,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic [3:0]              byteenable,
  input wire logic [31:0]             writedata,
  input wire logic [31:0]             readdata,
  input wire logic                    waitrequest,
  // Core and interrupt
  input wire conv_ctrl_pkg::core_req_s core_req,
  input wire logic [7:0]              conv_clock_config,
  input wire logic                    conv_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire take = !waitrequest && (read || write);
  wire [7:0] idx = address[9:2];
  wire st_wr = take && write && byteenable[0] && idx == IDX_STATUS_CONTROL;
  wire lo_rd = take && read && idx == IDX_RESULT_LOW;
  wire hi_rd = take && read && idx == IDX_RESULT_HIGH;
  wire cc_wr = take && write && byteenable[0] && idx == IDX_CLOCK_CONFIG;
  property p_start; st_wr && writedata[4:0] != CH_POWER_OFF |-> ##[1:2] core_req.start; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_chan; st_wr |=> core_req.channel == $past(writedata[4:0]); endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_off; core_req.power_down == (core_req.channel == CH_POWER_OFF); endproperty
  a_off: assert property (p_off) else $error("bad power down");
  property p_rst; $fell(rst) |-> !conv_irq && readdata == 32'h0 && conv_clock_config == CLKCFG_RESET; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_clr; st_wr || lo_rd |=> !conv_irq; endproperty
  a_clr: assert property (p_clr) else $error("irq not withdrawn");
  property p_hold; conv_irq && !st_wr && !lo_rd && !cc_wr |=> conv_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_flag; take && read && idx == IDX_STATUS_CONTROL && readdata[IRQEN_BIT] |-> !readdata[DONE_BIT]; endproperty
  a_flag: assert property (p_flag) else $error("done seen with irq on");
  property p_trunc; hi_rd && conv_clock_config[3:2] == 2'h0 |-> readdata[7:0] == 8'h00; endproperty
  a_trunc: assert property (p_trunc) else $error("high not zero");
  property p_time; $rose(core_req.start) && !conv_irq |=> !conv_irq [*8]; endproperty
  a_time: assert property (p_time) else $error("conversion too short");
  c_irq: cover property ($rose(conv_irq));
  c_lo: cover property (lo_rd);
  c_hi: cover property (hi_rd);
endmodule : conv_ctrl_chk

bind conv_ctrl conv_ctrl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .core_req(core_req), .conv_clock_config(conv_clock_config), .conv_irq(conv_irq));

// ==== sim/tb_conv_ctrl.sv ====
// Bench for conv_ctrl: bus master and converter core.
// Assumes a 20 MHz clock; conversions fed by tick pulses.
`timescale 1ns/1ps
module tb_conv_ctrl;
  import conv_ctrl_pkg::*;
  logic        sys_clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, conv_tick = 1'h0;
  logic [9:0]  address = 10'h0, sample = 10'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, conv_irq;
  logic [7:0]  rd;
  logic [7:0]  hi [4] = '{8'h00, 8'h02, 8'hB4, 8'h34};
  logic [7:0]  lo [4] = '{8'hB4, 8'hD3, 8'hC0, 8'hC0};
  core_req_s   core_req;
  int          errors = 0, tests_run = 0, cyc = 0;
  conv_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .conv_tick(conv_tick), .sample(sample), .core_req(core_req), .conv_clock_config(), .conv_irq(conv_irq));
  initial forever #25 sys_clk = ~sys_clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One idle edge after release so strobes never toggle twice in a step
  // Waitrequest is judged before the edge, never in the edge's own time step
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic ready;
    read <= !w;
    write <= w;
    address <= {idx, 2'h0};
    writedata <= {24'h0, d};
    ready = 1'b0;
    while (!ready)
    begin
      @(negedge sys_clk);
      ready = (waitrequest === 1'b0);
      @(posedge sys_clk);
    end
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rd_chk
  task automatic ticks(input int n);
    repeat (2) @(posedge sys_clk);
    repeat (n)
    begin
      conv_tick <= 1'b1;
      @(posedge sys_clk);
    end
    conv_tick <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : ticks
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(IDX_STATUS_CONTROL, 8'h1F);
    rd_chk(IDX_CLOCK_CONFIG, CLKCFG_RESET);
    rd_chk(8'h00, 8'h00);
    bus(1'b1, IDX_RESULT_LOW, 8'hFF);
    rd_chk(IDX_RESULT_LOW, 8'h00);
    sample <= 10'h2A5;
    bus(1'b1, IDX_STATUS_CONTROL, 8'h00);
    ticks(15);
    rd_chk(IDX_STATUS_CONTROL, 8'h00);
    ticks(2);
    rd_chk(IDX_STATUS_CONTROL, 8'h80);
    rd_chk(IDX_RESULT_HIGH, 8'h02);
    rd_chk(IDX_RESULT_LOW, 8'hA5);
    rd_chk(IDX_STATUS_CONTROL, 8'h00);
    ticks(17);
    rd_chk(IDX_STATUS_CONTROL, 8'h00);
    sample <= 10'h155;
    bus(1'b1, IDX_STATUS_CONTROL, 8'h20);
    ticks(17);
    rd_chk(IDX_RESULT_HIGH, 8'h01);
    sample <= 10'h0AA;
    ticks(34);
    rd_chk(IDX_RESULT_LOW, 8'h55);
    ticks(34);
    rd_chk(IDX_RESULT_LOW, 8'hAA);
    bus(1'b1, IDX_STATUS_CONTROL, 8'h1F);
    check({7'h0, core_req.power_down}, 8'h01);
    ticks(17);
    rd_chk(IDX_STATUS_CONTROL, 8'h1F);
    bus(1'b1, IDX_STATUS_CONTROL, {3'h0, CH_BANDGAP});
    ticks(17);
    sample <= 10'h2D3;
    for (int f = 0; f < 4; f++)
    begin
      bus(1'b1, IDX_CLOCK_CONFIG, 8'(f << 2));
      bus(1'b1, IDX_STATUS_CONTROL, {3'h0, CH_BANDGAP});
      check({3'h0, core_req.channel}, 8'h06);
      ticks(17);
      rd_chk(IDX_STATUS_CONTROL, 8'h86);
      bus(1'b1, IDX_CLOCK_CONFIG, 8'(f << 2));
      rd_chk(IDX_STATUS_CONTROL, 8'h06);
      rd_chk(IDX_RESULT_HIGH, hi[f]);
      rd_chk(IDX_RESULT_LOW, lo[f]);
    end
    bus(1'b1, IDX_STATUS_CONTROL, 8'h5D);
    ticks(17);
    rd_chk(IDX_STATUS_CONTROL, 8'h5D);
    rd_chk(IDX_RESULT_HIGH, 8'h34);
    check({7'h0, conv_irq}, 8'h01);
    rd_chk(IDX_RESULT_LOW, 8'hC0);
    check({7'h0, conv_irq}, 8'h00);
    ticks(17);
    bus(1'b1, IDX_STATUS_CONTROL, 8'h5E);
    check({7'h0, conv_irq}, 8'h00);
    check({3'h0, core_req.channel}, 8'h1E);
    wrap_up();
  end
endmodule : tb_conv_ctrl
